// ===== common/cfg_parse_pkg.sv
package cfg_parse_pkg;
	// stream framing
	localparam logic [4:0]  PREAMBLE_WIN = 5'h12;     // last one bit, then 0010
	localparam logic [15:0] ID_HDR       = 16'h5FFF;
	localparam logic [1:0]  MODE_AUTO    = 2'h0;
	localparam logic [1:0]  MODE_EXPL    = 2'h1;
	localparam logic [7:0]  POST_CHK     = 8'hFF;
	localparam int          LEN_BITS     = 24;
	localparam int          TRAIL_BITS   = 8;
	localparam int          IDHDR_BITS   = 16;
	localparam int          MODE_BITS    = 2;
	localparam int          RSVD_BITS    = 42;
	localparam int          PART_BITS    = 20;
	localparam int          IDBODY_BITS  = MODE_BITS + RSVD_BITS + PART_BITS;
	localparam int          CHK_BITS     = 8;
	localparam int          STOP_BITS    = 8;
	localparam int          POST_STOP    = 16;
	localparam int          START_BITS   = 2;
	localparam int          ADDR_BITS    = 14;
	localparam int          DATA_BITS    = 292;
	localparam int          FRAMES       = 1880;
	// last index of each field and the stop-bit minimum, at the field counter's width; then bits per host word
	localparam logic [8:0]  LEN_LAST     = 9'(LEN_BITS - 1);
	localparam logic [8:0]  TRAIL_LAST   = 9'(TRAIL_BITS - 1);
	localparam logic [8:0]  IDHDR_LAST   = 9'(IDHDR_BITS - 1);
	localparam logic [8:0]  IDBODY_LAST  = 9'(IDBODY_BITS - 1);
	localparam logic [8:0]  CHK_LAST     = 9'(CHK_BITS - 1);
	localparam logic [8:0]  STOP_MIN     = 9'(STOP_BITS);
	localparam logic [8:0]  POST_LAST    = 9'(POST_STOP - 1);
	localparam logic [8:0]  ADDR_LAST    = 9'(ADDR_BITS - 1);
	localparam logic [5:0]  WORD_BITS    = 6'h20;
	// values after reset
	localparam logic [2:0]  PIN_SYNC_RST = 3'h7;
	// error classes
	localparam logic [1:0]  ERR_NONE     = 2'h0;
	localparam logic [1:0]  ERR_ID       = 2'h1;
	localparam logic [1:0]  ERR_ALIGN    = 2'h2;
	localparam logic [1:0]  ERR_CSUM     = 2'h3;

	typedef enum logic [3:0] {
		ST_HUNT, ST_LEN, ST_TRAIL, ST_IDHDR, ST_IDBODY, ST_CHK, ST_STOP,
		ST_KIND, ST_DATA, ST_ALIGN, ST_ADDR, ST_DONE, ST_ERR
	} st_e;

	typedef enum logic [1:0] {FK_ID, FK_DATA, FK_ADDR, FK_POST} fk_e;
endpackage

// ===== verif/cfg_src.sv
`timescale 1ns/1ps
module cfg_src #(
	parameter int DB = cfg_parse_pkg::DATA_BITS // data bits per frame
) (
	input  wire logic core_clk,      // parser clock
	input  wire logic cfg_bit_ready, // parser takes a bit
	output logic      cfg_bit_in,    // stream bit
	output logic      cfg_bit_valid  // bit offered
);
	bit q[$];
	bit fb[$];
	bit hold;
	bit slow;
	bit took;
	bit gap;
	int lenpos;
	initial begin
		cfg_bit_in = 1'b0;
		cfg_bit_valid = 1'b0;
	end
	always @(posedge core_clk) begin
		took <= cfg_bit_valid && cfg_bit_ready;
	end
	// a bit stays offered until taken; an idle line flips so no stale level is read
	always @(negedge core_clk) begin
		if (took)
			void'(q.pop_front());
		if (!cfg_bit_valid || took) begin
			gap = slow && !gap;
			if (q.size() > 0 && !hold && !gap) begin
				cfg_bit_valid = 1'b1;
				cfg_bit_in = q[0];
			end else begin
				cfg_bit_valid = 1'b0;
				cfg_bit_in = ~cfg_bit_in;
			end
		end
	end
	task automatic put(input logic [DB-1:0] v, input int n);
		for (int i = n - 1; i >= 0; i--)
			fb.push_back(v[i]);
	endtask
	// lane i mod 8 of the checksum collects frame bit i; stops are one byte
	task automatic close(input bit bad, input bit zstop);
		logic [7:0] c;
		c = 8'h00;
		foreach (fb[i])
			c[i % 8] ^= fb[i];
		c[0] ^= bad;
		q = {q, fb};
		fb.delete();
		for (int i = 7; i >= 0; i--)
			q.push_back(c[i]);
		for (int i = 0; i < 8; i++)
			q.push_back(!(zstop && i == 3));
	endtask
	task automatic hdr(input int lead);
		repeat (lead) q.push_back(1'b1);
		lenpos = q.size() + 4;
		put(4'h2, 4);
		put(24'h0, 24);
		put(8'hFF, 8);
		q = {q, fb};
		fb.delete();
	endtask
	task automatic fix_len(input int extra);
		logic [23:0] n;
		n = 24'(q.size() + extra);
		for (int i = 0; i < 24; i++)
			q[lenpos + i] = n[23 - i];
	endtask
	task automatic id(input logic [1:0] m, input logic [19:0] p, input bit bad);
		put(cfg_parse_pkg::ID_HDR, 16);
		put(m, 2);
		put(42'h0, 42);
		put(p, 20);
		close(bad, 1'b0);
	endtask
	task automatic data(input logic [DB-1:0] d, input bit bad, input bit zs);
		put(2'h1, 2);
		put(d, DB);
		put(8'h0, (8 - (DB + 2) % 8) % 8);
		close(bad, zs);
	endtask
	task automatic addr(input logic [13:0] a, input bit bad);
		put(2'h0, 2);
		put(a, 14);
		close(bad, 1'b0);
	endtask
	task automatic post();
		repeat (2) q.push_back(1'b0);
		repeat (38) q.push_back(1'b1);
	endtask
endmodule

// ===== verif/config_bitstream_parser_tb_top.sv
`timescale 1ns/1ps
module config_bitstream_parser_tb_top;
	localparam int          DB   = cfg_parse_pkg::DATA_BITS;
	localparam logic [19:0] PART = 20'h5A5A5; // arbitrary value
	localparam logic [1:0]  AU   = cfg_parse_pkg::MODE_AUTO;
	localparam logic [1:0]  EX   = cfg_parse_pkg::MODE_EXPL;
	localparam logic [1:0]  EN   = cfg_parse_pkg::ERR_NONE;
	typedef struct {logic [1:0] mode; logic [19:0] part; int inj; logic [1:0] err; int nw;} row_s;
	logic          core_clk, rst, program_restart_pin_n, program_restart_bit, pci_path_sel;
	logic          cfg_bit_in, cfg_bit_valid, cfg_bit_ready, pci_word_valid, pci_word_ready;
	logic          ram_wr_valid, ram_wr_ready, init_n, load_done, explicit_mode, stalled;
	logic [31:0]   pci_cfg_data_word, w;
	logic [13:0]   ram_wr_addr;
	logic [DB-1:0] ram_wr_data;
	logic [1:0]    err_type;
	logic [13:0]   wa[$];
	logic [DB-1:0] wd[$];
	int            err_total, n_tests;
	row_s rows[8] = '{
		'{AU, PART, 0, EN, 2}, '{EX, PART, 0, EN, 3},
		'{AU, PART ^ 20'h00001, 0, cfg_parse_pkg::ERR_ID, 0},
		'{2'h2, PART, 0, cfg_parse_pkg::ERR_ID, 0}, '{2'h3, PART, 0, cfg_parse_pkg::ERR_ID, 0},
		'{AU, PART, 1, cfg_parse_pkg::ERR_CSUM, 0}, '{AU, PART, 2, cfg_parse_pkg::ERR_ALIGN, 1},
		'{EX, PART, 3, cfg_parse_pkg::ERR_CSUM, 0}};
	cfg_stream_parser #(.FRAMES(8), .PART_CODE(PART)) i_cfg_stream_parser (
		.core_clk              (core_clk),
		.rst                   (rst),
		.program_restart_pin_n (program_restart_pin_n),
		.program_restart_bit   (program_restart_bit),
		.pci_path_sel          (pci_path_sel),
		.cfg_bit_in            (cfg_bit_in),
		.cfg_bit_valid         (cfg_bit_valid),
		.cfg_bit_ready         (cfg_bit_ready),
		.pci_cfg_data_word     (pci_cfg_data_word),
		.pci_word_valid        (pci_word_valid),
		.pci_word_ready        (pci_word_ready),
		.ram_wr_valid          (ram_wr_valid),
		.ram_wr_ready          (ram_wr_ready),
		.ram_wr_addr           (ram_wr_addr),
		.ram_wr_data           (ram_wr_data),
		.init_n                (init_n),
		.load_done             (load_done),
		.err_type              (err_type),
		.explicit_mode         (explicit_mode)
	);
	cfg_src i_cfg_src (
		.core_clk      (core_clk),
		.cfg_bit_ready (cfg_bit_ready),
		.cfg_bit_in    (cfg_bit_in),
		.cfg_bit_valid (cfg_bit_valid)
	);
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		if (!rst && ram_wr_valid && ram_wr_ready) begin
			wa.push_back(ram_wr_addr);
			wd.push_back(ram_wr_data);
		end
		if (cfg_bit_ready === 1'b0)
			stalled <= 1'b1;
	end
	task automatic chk_v(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			err_total++;
			$display("Error %s expected %0h seen %0h", nm, e, g);
		end
	endtask
	task automatic chk_d(input string nm, input logic [DB-1:0] e, input logic [DB-1:0] g);
		n_tests++;
		if (g !== e) begin
			err_total++;
			$display("Error %s expected %0h seen %0h", nm, e, g);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d errors %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	function automatic logic [DB-1:0] pat(input int k);
		logic [319:0] v;
		v = {10{32'hC3A50F1E ^ k}};
		return v[DB-1:0];
	endfunction
	task automatic restart(input bit pin);
		@(negedge core_clk);
		if (pin)
			program_restart_pin_n = 1'b0;
		else
			program_restart_bit = 1'b1;
		cyc(6);
		program_restart_pin_n = 1'b1;
		program_restart_bit = 1'b0;
		cyc(6);
		wa.delete();
		wd.delete();
		stalled = 1'b0;
	endtask
	task automatic drain();
		int t;
		t = 0;
		while ((i_cfg_src.q.size() > 0 || cfg_bit_valid) && t < 4000) begin
			@(negedge core_clk);
			t++;
		end
		if (t >= 4000) begin
			err_total++;
			$display("Error drain expected idle seen timeout");
		end
		cyc(6);
	endtask
	task automatic run_row(input row_s r, input int k);
		logic [13:0] ea;
		restart(k[0]);
		chk_v("init_n", 1, init_n);
		chk_v("err_type", EN, err_type);
		i_cfg_src.hdr(4);
		i_cfg_src.id(r.mode, r.part, 1'b0);
		i_cfg_src.data(pat(k), r.inj == 1, r.inj == 2);
		if (r.mode == EX) begin
			i_cfg_src.addr(14'h0005, r.inj == 3);
			i_cfg_src.addr(14'h0002, 1'b0);
		end
		i_cfg_src.data(pat(k + 1), 1'b0, 1'b0);
		if (r.mode == EX)
			i_cfg_src.addr(14'h0007, 1'b0);
		i_cfg_src.post();
		i_cfg_src.fix_len(0);
		drain();
		chk_v("err_type", r.err, err_type);
		chk_v("init_n", r.err == EN, init_n);
		chk_v("load_done", r.err == EN, load_done);
		if (r.mode < 2)
			chk_v("explicit_mode", r.mode == EX, explicit_mode);
		chk_v("writes", r.nw, wa.size());
		for (int i = 0; i < wa.size() && i < r.nw; i++) begin
			ea = r.mode == EX ? (i == 0 ? 14'h5 : i == 1 ? 14'h2 : 14'h7) : 14'(i);
			chk_v("ram_wr_addr", ea, wa[i]);
			chk_d("ram_wr_data", pat(k + (r.mode == EX ? i / 2 : i)), wd[i]);
		end
	endtask
	task automatic chk_rst();
		chk_v("reset outputs", 8'hD0, {cfg_bit_ready, pci_word_ready, ram_wr_valid, init_n,
			load_done, err_type, explicit_mode});
	endtask
	initial begin
		rst = 1'b1;
		program_restart_pin_n = 1'b1;
		program_restart_bit = 1'b0;
		pci_path_sel = 1'b0;
		pci_cfg_data_word = 32'h0;
		pci_word_valid = 1'b0;
		ram_wr_ready = 1'b1;
		stalled = 1'b0;
		cyc(3);
		chk_rst();
		rst = 1'b0;
		foreach (rows[k])
			run_row(rows[k], k);
		// reset in mid-run, with an error still standing
		rst = 1'b1;
		cyc(2);
		chk_rst();
		rst = 1'b0;
		// slow source, length three bits longer than the stream
		restart(1'b0);
		i_cfg_src.slow = 1'b1;
		i_cfg_src.hdr(4);
		i_cfg_src.id(AU, PART, 1'b0);
		i_cfg_src.data(pat(20), 1'b0, 1'b0);
		i_cfg_src.post();
		i_cfg_src.fix_len(3);
		drain();
		chk_v("load_done", 0, load_done);
		repeat (3) i_cfg_src.q.push_back(1'b1);
		drain();
		chk_v("load_done", 1, load_done);
		i_cfg_src.slow = 1'b0;
		// ram stalls while address frames pile up; address 9 is past the array
		restart(1'b1);
		ram_wr_ready = 1'b0;
		i_cfg_src.hdr(4);
		i_cfg_src.id(EX, PART, 1'b0);
		i_cfg_src.data(pat(30), 1'b0, 1'b0);
		for (int a = 0; a < 4; a++)
			i_cfg_src.addr(14'(a), 1'b0);
		i_cfg_src.addr(14'h0009, 1'b0);
		i_cfg_src.post();
		i_cfg_src.fix_len(0);
		cyc(700);
		chk_v("cfg_bit_ready stall", 1, stalled);
		ram_wr_ready = 1'b1;
		drain();
		chk_v("writes", 4, wa.size());
		for (int i = 0; i < 4 && i < wa.size(); i++) begin
			chk_v("ram_wr_addr", i, wa[i]);
			chk_d("ram_wr_data", pat(30), wd[i]);
		end
		chk_v("load_done", 1, load_done);
		// host words: 28 leading ones make the stream exactly 16 words
		restart(1'b0);
		i_cfg_src.hold = 1'b1;
		i_cfg_src.hdr(28);
		i_cfg_src.id(AU, PART, 1'b0);
		i_cfg_src.data(pat(40), 1'b0, 1'b0);
		i_cfg_src.post();
		i_cfg_src.fix_len(0);
		pci_path_sel = 1'b1;
		while (i_cfg_src.q.size() > 0) begin
			for (int i = 31; i >= 0; i--)
				w[i] = i_cfg_src.q.pop_front();
			pci_cfg_data_word = w;
			pci_word_valid = 1'b1;
			for (int t = 0; t < 100 && pci_word_ready !== 1'b1; t++)
				@(negedge core_clk);
			if (pci_word_ready !== 1'b1) begin
				err_total++;
				$display("Error pci_word_ready expected 1 seen timeout");
			end
			@(negedge core_clk);
		end
		pci_word_valid = 1'b0;
		cyc(40);
		chk_v("writes", 1, wa.size());
		chk_d("ram_wr_data", pat(40), wd[0]);
		chk_v("load_done", 1, load_done);
		end_of_test();
	end
	initial begin
		#400000;
		err_total++;
		$display("Error watchdog expected finish seen timeout");
		end_of_test();
	end
endmodule

// ===== verilog/cfg_stream_parser.sv
`timescale 1ns/1ps
module cfg_stream_parser #(
	parameter int          DATA_BITS = cfg_parse_pkg::DATA_BITS, // data bits per frame
	parameter int          FRAMES    = cfg_parse_pkg::FRAMES,    // frames in the array
	parameter logic [19:0] PART_CODE = 20'h5A5A5                 // arbitrary value
) (
	input  wire logic                 core_clk,              // 100 MHz clock
	input  wire logic                 rst,                   // sync reset, high
	input  wire logic                 program_restart_pin_n, // restart pin, low active
	input  wire logic                 program_restart_bit,   // host restart bit
	input  wire logic                 pci_path_sel,          // bits from host word
	input  wire logic                 cfg_bit_in,            // serial stream bit
	input  wire logic                 cfg_bit_valid,         // stream bit present
	output logic                      cfg_bit_ready,         // parser takes a bit
	input  wire logic [31:0]          pci_cfg_data_word,     // host data word
	input  wire logic                 pci_word_valid,        // host word present
	output logic                      pci_word_ready,        // shift register empty
	output logic                      ram_wr_valid,          // frame write pending
	input  wire logic                 ram_wr_ready,          // ram takes write
	output logic [13:0]               ram_wr_addr,           // frame address
	output logic [DATA_BITS-1:0]      ram_wr_data,           // frame data
	output logic                      init_n,                // low after stream error
	output logic                      load_done,             // length count reached
	output logic [1:0]                err_type,              // error class
	output logic                      explicit_mode          // explicit addressing
);
	localparam int          ALIGN_N   = (8 - ((cfg_parse_pkg::START_BITS + DATA_BITS) % 8)) % 8;
	localparam logic [8:0]  DATA_LAST = 9'(DATA_BITS - 1);
	localparam logic [8:0]  ALGN_LAST = 9'(ALIGN_N - 1);

	cfg_parse_pkg::st_e st_r;
	cfg_parse_pkg::fk_e fk_r;
	logic [2:0]            pin_s_r;
	logic                  pin_lvl_r;
	logic [31:0]           sr_r;
	logic [5:0]            sr_cnt_r;
	logic [4:0]            hunt_r;
	logic [8:0]            fcnt_r;
	logic [2:0]            fpos_r;
	logic [7:0]            chk_r;
	logic [7:0]            rcv_r;
	logic [63:0]           sh_r;
	logic [23:0]           len_r;
	logic                  len_ok_r;
	logic [23:0]           bits_r;
	logic                  stop_bad_r;
	logic [13:0]           addr_r;
	logic [DATA_BITS-1:0]  data_r;
	logic [13:0]           b1_addr_r;
	logic [DATA_BITS-1:0]  b1_data_r;
	logic                  b1_v_r;
	logic                  restart;
	logic                  bit_in;
	logic                  src_valid;
	logic                  take;
	logic [7:0]            sum_nxt;
	logic [7:0]            rcv_nxt;
	logic                  chk_end;
	logic                  chk_ok;
	logic                  push;
	logic                  pop;
	logic                  full_nxt;
	logic [63:0]           body;

	// restart pin, three-stage synchroniser with agreement filter
	always_ff @(posedge core_clk) begin
		if (rst) begin
			pin_s_r   <= cfg_parse_pkg::PIN_SYNC_RST;
			pin_lvl_r <= 1'b1;
		end else begin
			pin_s_r <= {pin_s_r[1:0], program_restart_pin_n};
			if (pin_s_r[1] == pin_s_r[2])
				pin_lvl_r <= pin_s_r[2];
		end
	end

	always_comb begin
		restart   = !pin_lvl_r || program_restart_bit;
		bit_in    = pci_path_sel ? sr_r[31] : cfg_bit_in;
		src_valid = pci_path_sel ? (sr_cnt_r != 6'h00) : cfg_bit_valid;
		take      = src_valid && cfg_bit_ready;
		sum_nxt   = chk_r ^ (8'(bit_in) << fpos_r);
		rcv_nxt   = {rcv_r[6:0], bit_in};
		body      = {sh_r[62:0], bit_in};
		chk_end   = take && st_r == cfg_parse_pkg::ST_CHK && fcnt_r == cfg_parse_pkg::CHK_LAST;
		// postamble carries a fixed all-ones checksum instead of a sum
		chk_ok    = (fk_r == cfg_parse_pkg::FK_POST) ? rcv_nxt == cfg_parse_pkg::POST_CHK
			: rcv_nxt == chk_r;
		push      = chk_end && chk_ok && addr_r < 14'(FRAMES) &&
			((fk_r == cfg_parse_pkg::FK_DATA && !explicit_mode) ||
			 (fk_r == cfg_parse_pkg::FK_ADDR && explicit_mode));
		pop       = ram_wr_valid && ram_wr_ready;
		full_nxt  = (pop || !ram_wr_valid) ? (b1_v_r && push) : (b1_v_r || push);
	end

	// host word shift register; msb goes out first
	always_ff @(posedge core_clk) begin
		if (rst) begin
			sr_r           <= 32'h00000000;
			sr_cnt_r       <= 6'h00;
			pci_word_ready <= 1'b1;
		end else if (pci_word_valid && pci_word_ready) begin
			sr_r           <= pci_cfg_data_word;
			sr_cnt_r       <= cfg_parse_pkg::WORD_BITS;
			pci_word_ready <= 1'b0;
		end else if (take && pci_path_sel) begin
			sr_r           <= {sr_r[30:0], 1'b0};
			sr_cnt_r       <= sr_cnt_r - 6'h01;
			pci_word_ready <= sr_cnt_r == 6'h01;
		end
	end

	// frame parser
	always_ff @(posedge core_clk) begin
		if (rst || restart) begin
			st_r          <= cfg_parse_pkg::ST_HUNT;
			fk_r          <= cfg_parse_pkg::FK_ID;
			hunt_r        <= 5'h00;
			fcnt_r        <= 9'h000;
			fpos_r        <= 3'h0;
			chk_r         <= 8'h00;
			rcv_r         <= 8'h00;
			sh_r          <= 64'h0000000000000000;
			len_r         <= 24'h000000;
			len_ok_r      <= 1'b0;
			stop_bad_r    <= 1'b0;
			addr_r        <= 14'h0000;
			explicit_mode <= 1'b0;
			err_type      <= cfg_parse_pkg::ERR_NONE;
			init_n        <= 1'b1;
		end else if (take) begin
			fcnt_r <= fcnt_r + 9'h001;
			if (st_r inside {cfg_parse_pkg::ST_IDHDR, cfg_parse_pkg::ST_IDBODY,
					cfg_parse_pkg::ST_KIND, cfg_parse_pkg::ST_DATA,
					cfg_parse_pkg::ST_ALIGN, cfg_parse_pkg::ST_ADDR}) begin
				chk_r  <= sum_nxt;
				fpos_r <= fpos_r + 3'h1;
			end
			case (st_r)
			cfg_parse_pkg::ST_HUNT: begin
				hunt_r <= {hunt_r[3:0], bit_in};
				if ({hunt_r[3:0], bit_in} == cfg_parse_pkg::PREAMBLE_WIN) begin
					st_r   <= cfg_parse_pkg::ST_LEN;
					fcnt_r <= 9'h000;
				end
			end
			cfg_parse_pkg::ST_LEN: begin
				len_r <= {len_r[22:0], bit_in};
				if (fcnt_r == cfg_parse_pkg::LEN_LAST) begin
					len_ok_r <= 1'b1;
					st_r     <= cfg_parse_pkg::ST_TRAIL;
					fcnt_r   <= 9'h000;
				end
			end
			cfg_parse_pkg::ST_TRAIL: begin
				if (!bit_in) begin
					st_r     <= cfg_parse_pkg::ST_ERR;
					err_type <= cfg_parse_pkg::ERR_ALIGN;
					init_n   <= 1'b0;
				end else if (fcnt_r == cfg_parse_pkg::TRAIL_LAST) begin
					st_r   <= cfg_parse_pkg::ST_IDHDR;
					fcnt_r <= 9'h000;
					chk_r  <= 8'h00;
					fpos_r <= 3'h0;
				end
			end
			cfg_parse_pkg::ST_IDHDR: begin
				sh_r <= body;
				if (fcnt_r == cfg_parse_pkg::IDHDR_LAST) begin
					fcnt_r <= 9'h000;
					if (body[15:0] != cfg_parse_pkg::ID_HDR) begin
						st_r     <= cfg_parse_pkg::ST_ERR;
						err_type <= cfg_parse_pkg::ERR_ID;
						init_n   <= 1'b0;
					end else begin
						st_r <= cfg_parse_pkg::ST_IDBODY;
					end
				end
			end
			cfg_parse_pkg::ST_IDBODY: begin
				sh_r <= body;
				if (fcnt_r == cfg_parse_pkg::IDBODY_LAST) begin
					fcnt_r <= 9'h000;
					fk_r   <= cfg_parse_pkg::FK_ID;
					// reserved bits are covered by the checksum but not checked
					if (body[19:0] != PART_CODE || body[63:62] > cfg_parse_pkg::MODE_EXPL) begin
						st_r     <= cfg_parse_pkg::ST_ERR;
						err_type <= cfg_parse_pkg::ERR_ID;
						init_n   <= 1'b0;
					end else begin
						explicit_mode <= body[63:62] == cfg_parse_pkg::MODE_EXPL;
						st_r          <= cfg_parse_pkg::ST_CHK;
					end
				end
			end
			cfg_parse_pkg::ST_CHK: begin
				rcv_r <= rcv_nxt;
				if (chk_end) begin
					fcnt_r     <= 9'h000;
					stop_bad_r <= 1'b0;
					if (!chk_ok) begin
						st_r     <= cfg_parse_pkg::ST_ERR;
						err_type <= cfg_parse_pkg::ERR_CSUM;
						init_n   <= 1'b0;
					end else begin
						st_r <= cfg_parse_pkg::ST_STOP;
						if (fk_r == cfg_parse_pkg::FK_DATA && !explicit_mode)
							addr_r <= addr_r + 14'h0001;
					end
				end
			end
			cfg_parse_pkg::ST_STOP: begin
				if (fcnt_r == 9'h1FF)
					fcnt_r <= fcnt_r;
				if (fk_r == cfg_parse_pkg::FK_POST) begin
					if (!bit_in) begin
						st_r     <= cfg_parse_pkg::ST_ERR;
						err_type <= cfg_parse_pkg::ERR_ALIGN;
						init_n   <= 1'b0;
					end else if (fcnt_r == cfg_parse_pkg::POST_LAST) begin
						st_r <= cfg_parse_pkg::ST_DONE;
					end
				end else if (!bit_in && fcnt_r < cfg_parse_pkg::STOP_MIN) begin
					stop_bad_r <= 1'b1;
				end else if (!bit_in && stop_bad_r) begin
					st_r     <= cfg_parse_pkg::ST_ERR;
					err_type <= cfg_parse_pkg::ERR_ALIGN;
					init_n   <= 1'b0;
				end else if (!bit_in) begin
					// first start bit is zero, so the fresh sum stays zero
					st_r   <= cfg_parse_pkg::ST_KIND;
					fcnt_r <= 9'h000;
					chk_r  <= 8'h00;
					fpos_r <= 3'h1;
				end
			end
			cfg_parse_pkg::ST_KIND: begin
				fcnt_r <= 9'h000;
				fk_r   <= bit_in ? cfg_parse_pkg::FK_DATA : cfg_parse_pkg::FK_ADDR;
				st_r   <= bit_in ? cfg_parse_pkg::ST_DATA : cfg_parse_pkg::ST_ADDR;
			end
			cfg_parse_pkg::ST_DATA: begin
				data_r <= {data_r[DATA_BITS-2:0], bit_in};
				if (fcnt_r == DATA_LAST) begin
					fcnt_r <= 9'h000;
					st_r   <= (ALIGN_N == 0) ? cfg_parse_pkg::ST_CHK : cfg_parse_pkg::ST_ALIGN;
				end
			end
			cfg_parse_pkg::ST_ALIGN: begin
				if (fcnt_r == ALGN_LAST) begin
					fcnt_r <= 9'h000;
					st_r   <= cfg_parse_pkg::ST_CHK;
				end
			end
			cfg_parse_pkg::ST_ADDR: begin
				addr_r <= {addr_r[12:0], bit_in};
				if (fcnt_r == cfg_parse_pkg::ADDR_LAST) begin
					fcnt_r <= 9'h000;
					st_r   <= cfg_parse_pkg::ST_CHK;
					if ({addr_r[12:0], bit_in} == 14'h3FFF)
						fk_r <= cfg_parse_pkg::FK_POST;
				end
			end
			default: begin
				fcnt_r <= fcnt_r; // done or error: bits dropped
			end
			endcase
		end
	end

	// length count of bits taken outside the error state, counted from the first bit after restart
	always_ff @(posedge core_clk) begin
		if (rst || restart) begin
			bits_r    <= 24'h000000;
			load_done <= 1'b0;
		end else if (take && st_r != cfg_parse_pkg::ST_ERR) begin
			bits_r <= bits_r + 24'h000001;
			if (len_ok_r && bits_r + 24'h000001 == len_r)
				load_done <= 1'b1;
		end
	end

	// two-entry write buffer: head drives the ram port, second entry catches a stall
	always_ff @(posedge core_clk) begin
		if (rst) begin
			ram_wr_valid  <= 1'b0;
			b1_v_r        <= 1'b0;
			cfg_bit_ready <= 1'b1;
		end else begin
			cfg_bit_ready <= !full_nxt;
			if (pop || !ram_wr_valid) begin
				ram_wr_valid <= b1_v_r || push;
				ram_wr_addr  <= b1_v_r ? b1_addr_r : addr_r;
				ram_wr_data  <= b1_v_r ? b1_data_r : data_r;
				if (b1_v_r) begin
					b1_addr_r <= addr_r;
					b1_data_r <= data_r;
					b1_v_r    <= push;
				end
			end else if (push) begin
				b1_addr_r <= addr_r;
				b1_data_r <= data_r;
				b1_v_r    <= 1'b1;
			end
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	chk_err_sticky: assert property (st_r == cfg_parse_pkg::ST_ERR && !restart |=>
		st_r == cfg_parse_pkg::ST_ERR && $stable(bits_r))
		else $error("error state left without restart");
	chk_err_init_low: assert property (st_r == cfg_parse_pkg::ST_ERR |->
		!init_n && err_type != cfg_parse_pkg::ERR_NONE)
		else $error("init not low in error state");
	chk_preamble_sync: assert property (st_r == cfg_parse_pkg::ST_HUNT && take && !restart &&
		{hunt_r[3:0], bit_in} == cfg_parse_pkg::PREAMBLE_WIN |=> st_r == cfg_parse_pkg::ST_LEN)
		else $error("preamble not taken");
	chk_done_count: assert property (take && !restart && len_ok_r &&
		st_r != cfg_parse_pkg::ST_ERR && bits_r + 24'h000001 == len_r |=> load_done)
		else $error("done missing at length count");
	chk_part_check: assert property (take && !restart && st_r == cfg_parse_pkg::ST_IDBODY &&
		fcnt_r == cfg_parse_pkg::IDBODY_LAST && body[19:0] != PART_CODE |=>
		st_r == cfg_parse_pkg::ST_ERR && err_type == cfg_parse_pkg::ERR_ID)
		else $error("part code mismatch not flagged");
	chk_sum_check: assert property (chk_end && !restart && !chk_ok |=>
		err_type == cfg_parse_pkg::ERR_CSUM && !init_n)
		else $error("checksum mismatch not flagged");
	chk_align_err: assert property (take && !restart && st_r == cfg_parse_pkg::ST_STOP &&
		fk_r != cfg_parse_pkg::FK_POST && !bit_in && stop_bad_r &&
		fcnt_r >= cfg_parse_pkg::STOP_MIN |=> err_type == cfg_parse_pkg::ERR_ALIGN)
		else $error("alignment error not flagged");
	chk_auto_write: assert property (push && !restart && !explicit_mode |=>
		ram_wr_valid && addr_r == $past(addr_r) + 14'h0001)
		else $error("autoincrement write or address step missing");
	chk_one_bit: assert property (!take && !restart |=> $stable(st_r) && $stable(fcnt_r))
		else $error("parser moved without a bit");
	chk_word_shift: assert property (take && pci_path_sel && !(pci_word_valid && pci_word_ready)
		|=> sr_cnt_r == $past(sr_cnt_r) - 6'h01)
		else $error("host word shift count wrong");
	chk_buf_stall: assert property (ram_wr_valid && b1_v_r |-> !cfg_bit_ready)
		else $error("stream taken while buffer full");
	cov_load_done: cover property (load_done && init_n);
	cov_explicit_write: cover property (push && explicit_mode);
	cov_buf_full: cover property (ram_wr_valid && b1_v_r && !ram_wr_ready);
	cov_err_restart: cover property (st_r == cfg_parse_pkg::ST_ERR ##1 restart);
endmodule
